// ==== design/bstc_tap.sv ====
// boundary-scan test port controller with its test registers and a wishbone slave
// assumes tck/tms/tdi are asynchronous pins, much slower than clk_i
`timescale 1ns/10ps

module bstc_tap
	import bstc_pkg::*;
#(
	// arbitrary neutral identification value
	parameter logic [ID_W-1:0] ID_VALUE = 32'h0000_0001
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_n_o,
	input wire logic [BND_W-1:0] bnd_capture_i,
	output logic [BND_W-1:0] bnd_latch_o,
	output logic [BOP_W-1:0] bop_sel_o,
	output logic test_mode_o,
	output logic run_active_o,
	output logic [3:0] tap_state_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	bstc_pins_t pins_m_r;
	bstc_pins_t pins_s_r;
	logic tck_d_r;
	logic tck_rise;
	logic tck_fall;
	bstc_state_t state_r;
	bstc_state_t state_nxt;
	logic [IR_W-1:0] ir_shift_r;
	logic [IR_W-1:0] instr_r;
	logic [BND_W-1:0] bnd_shift_r;
	logic [BOP_W-1:0] bop_shift_r;
	logic bypass_r;
	logic [ID_W-1:0] id_shift_r;
	bstc_dr_t dr_sel;
	logic dr_lsb;
	logic force_tlr_r;
	logic wb_req;
	logic [2:0] tms_hi_cnt_r;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and test clock edges

	// two flops before anything reads the pins; left without reset so the
	// edge detector tracks the pin and sees no false edge after a reset
	always_ff @(posedge clk_i)
	begin
		pins_m_r <= '{tck: tck_i, tms: tms_i, tdi: tdi_i};
		pins_s_r <= pins_m_r;
		tck_d_r <= pins_s_r.tck;
	end

	// rising edge samples, falling edge drives
	assign tck_rise = pins_s_r.tck & ~tck_d_r;
	assign tck_fall = ~pins_s_r.tck & tck_d_r;

	////////////////////////////////////////////////////////////////////////
	// controller state machine

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_TLR: state_nxt = pins_s_r.tms ? ST_TLR : ST_RTI;
			ST_RTI: state_nxt = pins_s_r.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_nxt = pins_s_r.tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = pins_s_r.tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_nxt = pins_s_r.tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = pins_s_r.tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_nxt = pins_s_r.tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_nxt = pins_s_r.tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = pins_s_r.tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_nxt = pins_s_r.tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: state_nxt = pins_s_r.tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_nxt = pins_s_r.tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = pins_s_r.tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_nxt = pins_s_r.tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_nxt = pins_s_r.tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = pins_s_r.tms ? ST_SEL_DR : ST_RTI;
			default: state_nxt = ST_TLR;
		endcase
	end

	// step on rising test clock; power-up in reset state
	always_ff @(posedge clk_i)
	begin
		if (rst_i || force_tlr_r)
			state_r <= ST_TLR;
		else if (tck_rise)
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// instruction register

	// fixed capture pattern; shift one bit per rise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ir_shift_r <= IR_RESET;
		else if (tck_rise && state_r == ST_CAP_IR)
			ir_shift_r <= IR_CAPTURE;
		else if (tck_rise && state_r == ST_SH_IR)
			ir_shift_r <= {pins_s_r.tdi, ir_shift_r[IR_W-1:1]};
	end

	// id opcode in reset; update on falling edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_r == ST_TLR)
			instr_r <= IR_RESET;
		else if (tck_fall && state_r == ST_UPD_IR)
			instr_r <= ir_shift_r;
	end

	////////////////////////////////////////////////////////////////////////
	// data registers, shift stages

	// unknown opcodes fall to bypass; one register at a time
	assign dr_sel = bstc_dr_sel(instr_r);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bnd_shift_r <= '0;
		else if (tck_rise && dr_sel == DR_BOUND && state_r == ST_CAP_DR)
			bnd_shift_r <= bnd_capture_i;
		else if (tck_rise && dr_sel == DR_BOUND && state_r == ST_SH_DR)
			bnd_shift_r <= {pins_s_r.tdi, bnd_shift_r[BND_W-1:1]};
	end

	// no capture into the operation select stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bop_shift_r <= BOP_RESET;
		else if (tck_rise && dr_sel == DR_BOP && state_r == ST_SH_DR)
			bop_shift_r <= {pins_s_r.tdi, bop_shift_r[BOP_W-1:1]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bypass_r <= 1'b0;
		else if (tck_rise && dr_sel == DR_BYPASS && state_r == ST_CAP_DR)
			bypass_r <= 1'b0;
		else if (tck_rise && dr_sel == DR_BYPASS && state_r == ST_SH_DR)
			bypass_r <= pins_s_r.tdi;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			id_shift_r <= ID_VALUE;
		else if (tck_rise && dr_sel == DR_IDENT && state_r == ST_CAP_DR)
			id_shift_r <= ID_VALUE;
		else if (tck_rise && dr_sel == DR_IDENT && state_r == ST_SH_DR)
			id_shift_r <= {pins_s_r.tdi, id_shift_r[ID_W-1:1]};
	end

	////////////////////////////////////////////////////////////////////////
	// update latches

	// boundary latches; drive cells cleared in reset state
	// one process, so the latch word has a single driver
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bnd_latch_o <= '0;
		else if (state_r == ST_TLR)
			bnd_latch_o[BND_FLOAT_HI:BND_FLOAT_LO] <= '0;
		else if (tck_fall && state_r == ST_UPD_DR && dr_sel == DR_BOUND)
			bnd_latch_o <= bnd_shift_r;
	end

	// signature analysis after reset; update on fall
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_r == ST_TLR)
			bop_sel_o <= BOP_RESET;
		else if (tck_fall && state_r == ST_UPD_DR && dr_sel == DR_BOP)
			bop_sel_o <= bop_shift_r;
	end

	////////////////////////////////////////////////////////////////////////
	// serial output

	always_comb
	begin
		case (dr_sel)
			DR_BOUND: dr_lsb = bnd_shift_r[0];
			DR_BOP: dr_lsb = bop_shift_r[0];
			DR_IDENT: dr_lsb = id_shift_r[0];
			default: dr_lsb = bypass_r;
		endcase
	end

	// drive lsb in shift; float elsewhere, exit-1 included
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tdo_o <= 1'b0;
			tdo_oe_n_o <= 1'b1;
		end
		else if (tck_fall)
		begin
			tdo_o <= (state_r == ST_SH_IR) ? ir_shift_r[0] : dr_lsb;
			tdo_oe_n_o <= !(state_r == ST_SH_IR || state_r == ST_SH_DR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode outputs

	// boundary operation only while idling under the run opcode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			test_mode_o <= 1'b0;
			run_active_o <= 1'b0;
			tap_state_o <= ST_TLR;
		end
		else
		begin
			test_mode_o <= bstc_is_test(instr_r) && state_r != ST_TLR;
			run_active_o <= state_r == ST_RTI && instr_r == OP_RUNT;
			tap_state_o <= state_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wishbone slave, answers every address with one ack

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			force_tlr_r <= 1'b0;
		else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
			force_tlr_r <= wb_dat_i[CTRL_FORCE_TLR];
	end

	// unmapped offsets read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (wb_req)
		begin
			wb_dat_o <= '0;
			case (wb_adr_i)
				ADR_CTRL: wb_dat_o[CTRL_FORCE_TLR] <= force_tlr_r;
				ADR_STATUS:
				begin
					wb_dat_o[3:0] <= state_r;
					wb_dat_o[STAT_DRIVE] <= !tdo_oe_n_o;
					wb_dat_o[STAT_TEST] <= test_mode_o;
					wb_dat_o[STAT_RUN] <= run_active_o;
				end
				ADR_INSTR: wb_dat_o[IR_W-1:0] <= instr_r;
				ADR_BOP: wb_dat_o[BOP_W-1:0] <= bop_sel_o;
				default: wb_dat_o <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	always_ff @(posedge clk_i)
	begin
		if (rst_i || force_tlr_r)
			tms_hi_cnt_r <= '0;
		else if (tck_rise)
			tms_hi_cnt_r <= pins_s_r.tms ? ((tms_hi_cnt_r == 3'h7) ? 3'h7 : tms_hi_cnt_r + 3'h1)
				: 3'h0;
	end

	a_tms_high_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		tms_hi_cnt_r >= 3'(TLR_MAX_TCK) |-> state_r == ST_TLR)
		else $error("five high tms did not reach reset state");

	a_tdo_fall_only: assert property (@(posedge clk_i) disable iff (rst_i)
		($changed(tdo_o) || $changed(tdo_oe_n_o)) |-> $past(tck_fall))
		else $error("serial output moved away from a falling edge");

	a_ir_reset_value: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_TLR |=> instr_r == IR_RESET)
		else $error("instruction not reset to id opcode");

	a_bop_reset_value: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_TLR |=> bop_sel_o == BOP_RESET && bnd_latch_o[43:40] == 4'h0)
		else $error("reset values missing in reset state");

	a_select_leaves: assert property (@(posedge clk_i) disable iff (rst_i || force_tlr_r)
		tck_rise && (state_r == ST_SEL_DR || state_r == ST_SEL_IR)
		|=> state_r != $past(state_r))
		else $error("select state held past one test clock");

	a_ir_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_rise && state_r == ST_CAP_IR |=> ir_shift_r == IR_CAPTURE)
		else $error("instruction capture pattern wrong");

	a_ir_shift_step: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_rise && state_r == ST_SH_IR
		|=> ir_shift_r == {$past(pins_s_r.tdi), $past(ir_shift_r[IR_W-1:1])})
		else $error("instruction shift step wrong");

	a_bypass_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_rise && state_r == ST_CAP_DR && dr_sel == DR_BYPASS |=> !bypass_r)
		else $error("bypass did not capture zero");

	a_tdo_drive_shift: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_fall && state_r == ST_SH_DR |=> !tdo_oe_n_o && tdo_o == $past(dr_lsb))
		else $error("serial output not driving lsb in shift");

	a_tdo_float_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_fall && (state_r == ST_EX1_DR || state_r == ST_EX1_IR) |=> tdo_oe_n_o)
		else $error("serial output still driven in exit state");

	a_pause_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_PAU_IR |=> $stable(ir_shift_r))
		else $error("instruction stage changed in pause");

	a_ir_update: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_fall && state_r == ST_UPD_IR |=> instr_r == $past(ir_shift_r))
		else $error("instruction not updated on falling edge");

	a_run_only_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		run_active_o |-> $past(state_r) == ST_RTI)
		else $error("operation running outside idle state");

	a_dr_pause_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_PAU_DR |=> $stable(bnd_shift_r) && $stable(bop_shift_r)
			&& $stable(bypass_r) && $stable(id_shift_r))
		else $error("data stage changed in pause");

	a_bop_no_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_rise && state_r == ST_CAP_DR && dr_sel == DR_BOP |=> $stable(bop_shift_r))
		else $error("operation select stage changed in capture");

	a_id_capture: assert property (@(posedge clk_i) disable iff (rst_i)
		tck_rise && state_r == ST_CAP_DR && dr_sel == DR_IDENT |=> id_shift_r == ID_VALUE)
		else $error("identification value not captured");

	a_test_off_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		state_r == ST_TLR |=> !test_mode_o && !run_active_o)
		else $error("test mode active in reset state");

endmodule // bstc_tap

// ==== design/bstc_pkg.sv ====
// constants, types and decoders for the boundary-scan test port controller
// assumes a 100 MHz system clock that samples the slow four-wire test bus

package bstc_pkg;

	localparam int IR_W = 8;
	localparam int BND_W = 44;
	localparam int BOP_W = 3;
	localparam int ID_W = 32;
	localparam int BND_FLOAT_HI = 43;
	localparam int BND_FLOAT_LO = 40;
	localparam int TLR_MAX_TCK = 5;

	localparam logic [IR_W-1:0] IR_RESET = 8'h81;
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
	localparam logic [BOP_W-1:0] BOP_RESET = 3'h2;

	// opcodes, even parity in bit 7
	localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
	localparam logic [IR_W-1:0] OP_IDCODE = 8'h81;
	localparam logic [IR_W-1:0] OP_SAMPLE = 8'h82;
	localparam logic [IR_W-1:0] OP_RUNT = 8'h09;
	localparam logic [IR_W-1:0] OP_SCANBOP = 8'h8e;
	localparam logic [IR_W-1:0] OP_BYPASS = 8'hff;

	// wishbone word offsets (byte addresses)
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_INSTR = 8'h08;
	localparam logic [7:0] ADR_BOP = 8'h0c;
	localparam int CTRL_FORCE_TLR = 0;
	localparam int STAT_DRIVE = 4;
	localparam int STAT_TEST = 5;
	localparam int STAT_RUN = 6;

	typedef enum logic [3:0] {
		ST_EX2_DR = 4'b0000,
		ST_EX1_DR = 4'b0001,
		ST_SH_DR = 4'b0010,
		ST_PAU_DR = 4'b0011,
		ST_SEL_IR = 4'b0100,
		ST_UPD_DR = 4'b0101,
		ST_CAP_DR = 4'b0110,
		ST_SEL_DR = 4'b0111,
		ST_EX2_IR = 4'b1000,
		ST_EX1_IR = 4'b1001,
		ST_SH_IR = 4'b1010,
		ST_PAU_IR = 4'b1011,
		ST_RTI = 4'b1100,
		ST_UPD_IR = 4'b1101,
		ST_CAP_IR = 4'b1110,
		ST_TLR = 4'b1111
	} bstc_state_t;

	typedef enum logic [1:0] {
		DR_BYPASS = 2'b00,
		DR_BOUND = 2'b01,
		DR_BOP = 2'b10,
		DR_IDENT = 2'b11
	} bstc_dr_t;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} bstc_pins_t;

	function automatic bstc_dr_t bstc_dr_sel(input logic [IR_W-1:0] op);
		case (op)
			OP_EXTEST, OP_SAMPLE, OP_RUNT: bstc_dr_sel = DR_BOUND;
			OP_IDCODE: bstc_dr_sel = DR_IDENT;
			OP_SCANBOP: bstc_dr_sel = DR_BOP;
			default: bstc_dr_sel = DR_BYPASS;
		endcase
	endfunction

	function automatic logic bstc_is_test(input logic [IR_W-1:0] op);
		bstc_is_test = (op == OP_EXTEST) || (op == OP_RUNT);
	endfunction

endpackage

// ==== tb/bstc_tester.sv ====
// serial test master model: makes tck, steers tms, shifts tdi, samples tdo
// assumes the bench clock at 10 ns; tck period is 8 of those, 80 ns
`timescale 1ns/10ps
module bstc_tester (
	input wire logic clk_i,
	input wire logic tdo_i,
	input wire logic tdo_oe_n_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	logic drove;
	logic last_oe_n;
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		drove = 1'b0;
		last_oe_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// tms and tdi set at the fall, stable over the rise
	// low three, high five: the new state is on tap_state_o before return
	task automatic step(input logic ms, input logic di, output logic d);
		tck_o <= 1'b0;
		tms_o <= ms;
		tdi_o <= di;
		repeat (3) @(posedge clk_i);
		tck_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		// mid-high sample: tdo only moves after a fall; undriven tdo reads inverted
		d = tdo_oe_n_i ? !tdo_i : tdo_i;
		last_oe_n = tdo_oe_n_i;
		drove = drove & ~tdo_oe_n_i;
		repeat (3) @(posedge clk_i);
	endtask
	// tdi left at its pull-up level outside shifts
	task automatic moves(input logic [7:0] ms, input int n);
		logic b;
		for (int i = 0; i < n; i++)
			step(ms[i], 1'b1, b);
	endtask
	task automatic shift(input int n, input logic [43:0] din, output logic [43:0] dout);
		logic b;
		dout = '0;
		drove = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], b);
			dout[i] = b;
		end
	endtask
endmodule // bstc_tester

// ==== tb/tb.sv ====
// self-checking bench for the scan port controller
// assumes bstc_tester on the test pins; wishbone master lives here
`timescale 1ns/10ps
module tb import bstc_pkg::*;;
	// arbitrary id value
	localparam logic [ID_W-1:0] ID_VAL = 32'h5a3c_9e17;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tck, tms, tdi, tdo, oen, tmode, run, ack, we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic [BND_W-1:0] cap = 44'h9a5_c3e1_7b24;
	logic [BND_W-1:0] lat;
	logic [BOP_W-1:0] bop;
	logic [3:0] st;
	logic [3:0] sel = 4'hf;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic [43:0] o;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	bstc_tester m (.clk_i(clk_i), .tdo_i(tdo), .tdo_oe_n_i(oen), .tck_o(tck), .tms_o(tms),
		.tdi_o(tdi));
	bstc_tap #(.ID_VALUE(ID_VAL)) dut (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(oen), .bnd_capture_i(cap), .bnd_latch_o(lat),
		.bop_sel_o(bop), .test_mode_o(tmode), .run_active_o(run), .tap_state_o(st),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack));
	initial
		forever #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			fails++;
		end
	endtask
	// one classic cycle, waits for ack with no assumed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		we <= w;
		adr <= a;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic load_ir(input logic [7:0] op);
		m.moves(8'h03, 4);
		m.shift(8, {36'h0, op}, o);
		m.moves(8'h01, 2);
		chk("ir_capture", 44'h81, o);
	endtask
	task automatic dr(input int n, input logic [43:0] din);
		m.moves(8'h01, 3);
		m.shift(n, din, o);
		chk("oe_shift", 44'h1, {43'h0, m.drove});
		m.moves(8'h01, 1);
		chk("oe_exit", 44'h1, {43'h0, m.last_oe_n});
		m.moves(8'h00, 1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("state", 44'hf, st);
		chk("oe_n", 44'h1, oen);
		chk("bop", 44'h2, bop);
		chk("lat_hi", 44'h0, lat[43:40]);
		wb(1'b0, ADR_INSTR, 32'h0);
		chk("instr", 44'h81, q);
	endtask
	task automatic t_walk();
		logic [19:0] ms;
		logic [79:0] exp;
		ms = 20'hed3d2;
		exp = 80'hf47cd8b9ae475031267c;
		for (int i = 0; i < 20; i++)
		begin
			m.moves({7'h0, ms[i]}, 1);
			chk("walk", exp[4*i+:4], st);
		end
	endtask
	task automatic t_idcode();
		m.moves(8'h00, 1);
		dr(32, 44'h0);
		chk("idcode", ID_VAL, o);
	endtask
	task automatic t_bypass();
		logic [7:0] ops [2];
		ops = '{OP_BYPASS, 8'h03};
		for (int i = 0; i < 2; i++)
		begin
			load_ir(ops[i]);
			dr(9, 44'h1b5);
			chk("bypass", {35'h0, 8'hb5, 1'b0}, o);
		end
	endtask
	task automatic t_bop();
		load_ir(OP_SCANBOP);
		dr(3, 44'h5);
		chk("bop_cap", 44'h2, o);
		chk("bop_lat", 44'h5, bop);
		wb(1'b0, ADR_BOP, 32'h0);
		chk("bop_rd", 44'h5, q);
	endtask
	task automatic t_bound();
		logic [43:0] din;
		logic [43:0] o1;
		din = 44'h3c6_5a0f_d219;
		load_ir(OP_SAMPLE);
		m.moves(8'h01, 3);
		m.shift(20, din, o1);
		m.moves(8'h08, 5);
		chk("lat_pause", 44'h0, lat);
		m.shift(24, din >> 20, o);
		m.moves(8'h01, 2);
		chk("bnd_out", cap, {o[23:0], o1[19:0]});
		chk("bnd_lat", din, lat);
	endtask
	task automatic t_runt();
		load_ir(OP_EXTEST);
		chk("tmode_ext", 44'h1, tmode);
		chk("run_ext", 44'h0, run);
		load_ir(OP_RUNT);
		chk("tmode", 44'h1, tmode);
		chk("run", 44'h1, run);
		m.moves(8'h01, 1);
		chk("run_off", 44'h0, run);
	endtask
	task automatic t_tlr();
		m.moves(8'h00, 2);
		chk("sh_dr", 44'h2, st);
		m.moves(8'h1f, 5);
		chk("tlr", 44'hf, st);
		chk("tmode_off", 44'h0, tmode);
		chk("lat_rst", 44'h0, lat[43:40]);
		wb(1'b0, ADR_INSTR, 32'h0);
		chk("instr_rst", 44'h81, q);
	endtask
	task automatic t_wb();
		wb(1'b1, ADR_CTRL, 32'h1);
		m.moves(8'h00, 3);
		chk("held", 44'hf, st);
		wb(1'b0, ADR_STATUS, 32'h0);
		chk("status", 44'hf, q[3:0]);
		wb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 44'h0, q);
		wb(1'b1, ADR_CTRL, 32'h0);
		m.moves(8'h00, 1);
		chk("idle", 44'hc, st);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		t_reset();
		t_walk();
		t_idcode();
		t_bypass();
		t_bop();
		t_bound();
		t_runt();
		t_tlr();
		t_wb();
		finish_test();
	end
endmodule // tb
